// File: core/csr_hdr_ecc.v
// Purpose: packet header code check and single-bit repair
// Assumes: header {code[31:24], count[23:8], id[7:0]}
// Notes: purely combinational
`timescale 1ns/1ps
`include "csr_consts.vh"
module csr_hdr_ecc (
   input wire [31:0] hdr,
   output wire [23:0] fixed,
   output wire zero,
   output wire single,
   output wire multi
);
   wire [5:0] calc;
   wire [5:0] syn;
   wire [23:0] hit;
   wire par_one;
   assign calc[0] = ^(hdr[23:0] & `CSR_ECC_M0);
   assign calc[1] = ^(hdr[23:0] & `CSR_ECC_M1);
   assign calc[2] = ^(hdr[23:0] & `CSR_ECC_M2);
   assign calc[3] = ^(hdr[23:0] & `CSR_ECC_M3);
   assign calc[4] = ^(hdr[23:0] & `CSR_ECC_M4);
   assign calc[5] = ^(hdr[23:0] & `CSR_ECC_M5);
   assign syn = calc ^ hdr[29:24];
   genvar j;
   generate
      for (j = 0; j < 24; j = j + 1) begin : g_col
         wire [23:0] m5 = `CSR_ECC_M5;
         wire [23:0] m4 = `CSR_ECC_M4;
         wire [23:0] m3 = `CSR_ECC_M3;
         wire [23:0] m2 = `CSR_ECC_M2;
         wire [23:0] m1 = `CSR_ECC_M1;
         wire [23:0] m0 = `CSR_ECC_M0;
         assign hit[j] = (syn == {m5[j], m4[j], m3[j], m2[j], m1[j], m0[j]});
      end
   endgenerate
   // a lone flipped code bit in 29:24 is also repairable
   assign par_one = (syn != 6'h00) && ((syn & (syn - 6'h01)) == 6'h00);
   assign zero = (syn == 6'h00) && (hdr[31:30] == 2'h0);
   assign single = !zero && ((|hit) || par_one);
   assign multi = !zero && !single;
   assign fixed = hdr[23:0] ^ hit;
endmodule // csr_hdr_ecc

// File: core/csr_lane_fsm.v
// Purpose: low-power line state tracker for one logical lane
// Assumes: p and n already synchronised and mapped
// Notes: clock lane enters sleep straight after escape request
`timescale 1ns/1ps
`include "csr_consts.vh"
module csr_lane_fsm #(
   parameter IS_CLK = 0
) (
   input wire clk,
   input wire reset_n,
   input wire lp_p,
   input wire lp_n,
   input wire [11:0] settle_ns,
   output wire in_hs,
   output wire hs_settled,
   output wire in_ulps,
   output reg esc_unknown,
   output reg seq_fault
);
   localparam [2:0] ST_STOP = 3'h0, ST_HSRQ = 3'h1, ST_HS = 3'h2, ST_ESRQ = 3'h3;
   localparam [2:0] ST_ECMD = 3'h4, ST_EMRK = 3'h5, ST_EDONE = 3'h6, ST_ULPS = 3'h7;
   reg [2:0] st_ff, nxt_st;
   reg [7:0] cmd_ff, nxt_cmd;
   reg [2:0] cnt_ff, nxt_cnt;
   reg [11:0] el_ff, nxt_el;
   reg nxt_unk, nxt_flt;
   wire [1:0] lp = {lp_p, lp_n};
   assign in_hs = (st_ff == ST_HS);
   assign hs_settled = in_hs && (el_ff >= settle_ns);
   assign in_ulps = (st_ff == ST_ULPS);
   // ****************************************
   // line state sequence
   // ****************************************
   always @* begin
      nxt_st = st_ff;
      nxt_cmd = cmd_ff;
      nxt_cnt = cnt_ff;
      nxt_el = el_ff;
      nxt_unk = 1'b0;
      nxt_flt = 1'b0;
      if (in_hs && !hs_settled) begin
         nxt_el = el_ff + `CSR_CLK_NS;
      end
      case (st_ff)
         ST_STOP: begin
            if (lp == `CSR_LP01) nxt_st = ST_HSRQ;
            else if (lp == `CSR_LP10) nxt_st = ST_ESRQ;
            else if (lp == `CSR_LP00) nxt_flt = 1'b1;
         end
         ST_HSRQ: begin
            if (lp == `CSR_LP00) begin
               nxt_st = ST_HS;
               nxt_el = 12'h000;
            end else if (lp == `CSR_LP11) begin
               nxt_st = ST_STOP;
            end else if (lp == `CSR_LP10) begin
               nxt_st = ST_STOP;
               nxt_flt = 1'b1;
            end
         end
         ST_HS: begin
            if (lp == `CSR_LP11) nxt_st = ST_STOP;
         end
         ST_ESRQ: begin
            if (lp == `CSR_LP00) begin
               nxt_st = IS_CLK ? ST_ULPS : ST_ECMD;
               nxt_cnt = 3'h0;
            end else if (lp == `CSR_LP11) begin
               nxt_st = ST_STOP;
            end else if (lp == `CSR_LP01) begin
               nxt_st = ST_STOP;
               nxt_flt = 1'b1;
            end
         end
         ST_ECMD: begin
            if (lp == `CSR_LP11) begin
               nxt_st = ST_STOP;
               nxt_flt = 1'b1;
            end else if (lp != `CSR_LP00) begin
               nxt_cmd = {cmd_ff[6:0], lp_p};
               nxt_cnt = cnt_ff + 3'h1;
               nxt_st = ST_EMRK;
            end
         end
         ST_EMRK: begin
            if (lp == `CSR_LP11) begin
               nxt_st = ST_STOP;
               nxt_flt = 1'b1;
            end else if (lp == `CSR_LP00) begin
               if (cnt_ff != 3'h0) begin
                  nxt_st = ST_ECMD;
               end else if (cmd_ff == `CSR_ESC_ULPS) begin
                  nxt_st = ST_ULPS;
               end else begin
                  nxt_st = ST_EDONE;
                  nxt_unk = (cmd_ff != `CSR_ESC_LPDT) && (cmd_ff != `CSR_ESC_RST);
               end
            end
         end
         ST_EDONE: begin
            if (lp == `CSR_LP11) nxt_st = ST_STOP;
         end
         ST_ULPS: begin
            if (lp == `CSR_LP11) nxt_st = ST_STOP;
         end
         default: nxt_st = ST_STOP;
      endcase
   end
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= ST_STOP;
         cmd_ff <= 8'h00;
         cnt_ff <= 3'h0;
         el_ff <= 12'h000;
         esc_unknown <= 1'b0;
         seq_fault <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cmd_ff <= nxt_cmd;
         cnt_ff <= nxt_cnt;
         el_ff <= nxt_el;
         esc_unknown <= nxt_unk;
         seq_fault <= nxt_flt;
      end
   end
endmodule // csr_lane_fsm

// File: core/csr_rx_status.v
// Purpose: error and sleep status of a four-lane camera receiver
// Assumes: clk is the pixel clock; packet and leader inputs come from logic on clk
// Notes: pads are asynchronous and pass two flip-flops
`timescale 1ns/1ps
`include "csr_consts.vh"
module csr_rx_status #(
   parameter [15:0] HS_TIMEOUT_CYC = `CSR_HS_TMO_CYC,
   parameter [15:0] MAX_WORD_COUNT = `CSR_MAX_WC
) (
   input wire clk,
   input wire reset_n,
   input wire [4:0] lane_positive_pads,
   input wire [4:0] lane_negative_pads,
   input wire [14:0] lane_role_select,
   input wire [4:0] lane_pn_swap,
   input wire [1:0] lane_count,
   input wire [3:0] channel_enable,
   input wire [11:0] clock_lane_settle_time,
   input wire [11:0] data_lane_settle_time,
   input wire status_enable,
   input wire clear,
   input wire leader_valid,
   input wire [7:0] leader_byte,
   input wire pkt_hdr_valid,
   input wire [31:0] pkt_hdr,
   input wire pkt_crc_valid,
   input wire pkt_crc_ok,
   output reg [17:0] error_status,
   output reg clock_lane_sleep_flag,
   output reg [3:0] data_lane_sleep_flags
);
   // ****************************************
   // pad synchronisers
   // ****************************************
   reg [4:0] p_meta_ff, n_meta_ff, p_ff, n_ff;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         p_meta_ff <= 5'h1F;
         n_meta_ff <= 5'h1F;
         p_ff <= 5'h1F;
         n_ff <= 5'h1F;
      end else begin
         p_meta_ff <= lane_positive_pads;
         n_meta_ff <= lane_negative_pads;
         p_ff <= p_meta_ff;
         n_ff <= n_meta_ff;
      end
   end

   // ****************************************
   // settle clamp
   // ****************************************
   wire [11:0] clk_settle;
   wire [11:0] dat_settle;
   assign clk_settle = (clock_lane_settle_time < `CSR_SETTLE_MIN_NS) ? `CSR_SETTLE_MIN_NS :
                       (clock_lane_settle_time > `CSR_SETTLE_MAX_NS) ? `CSR_SETTLE_MAX_NS :
                       clock_lane_settle_time;
   assign dat_settle = (data_lane_settle_time < `CSR_SETTLE_MIN_NS) ? `CSR_SETTLE_MIN_NS :
                       (data_lane_settle_time > `CSR_SETTLE_MAX_NS) ? `CSR_SETTLE_MAX_NS :
                       data_lane_settle_time;

   // ****************************************
   // lane mapping and line trackers
   // ****************************************
   wire [4:0] l_hs, l_set, l_ulps, l_unk, l_flt;
   wire [3:0] dl_on;
   assign dl_on[0] = 1'b1;
   assign dl_on[1] = (lane_count != 2'h0);
   assign dl_on[2] = (lane_count == 2'h3);
   assign dl_on[3] = (lane_count == 2'h3);
   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : g_lane
         localparam [2:0] LID = g;
         reg mp, mn;
         integer k;
         // logical lane 0 is the clock lane, 1..4 are data lanes 0..3
         always @* begin
            mp = 1'b1;
            mn = 1'b1;
            for (k = 0; k < 5; k = k + 1) begin
               if (lane_role_select[3*k +: 3] == LID) begin
                  mp = lane_pn_swap[k] ? n_ff[k] : p_ff[k];
                  mn = lane_pn_swap[k] ? p_ff[k] : n_ff[k];
               end
            end
         end
         csr_lane_fsm #(
            .IS_CLK(g == 0)
         ) u_fsm (
            .clk(clk),
            .reset_n(reset_n),
            .lp_p(mp),
            .lp_n(mn),
            .settle_ns((g == 0) ? clk_settle : dat_settle),
            .in_hs(l_hs[g]),
            .hs_settled(l_set[g]),
            .in_ulps(l_ulps[g]),
            .esc_unknown(l_unk[g]),
            .seq_fault(l_flt[g])
         );
      end
   endgenerate
   wire esc_fault = |(l_unk & {dl_on, 1'b1});
   wire ctrl_fault = |(l_flt & {dl_on, 1'b1});

   // ****************************************
   // high-speed receive timeout
   // ****************************************
   reg [15:0] tmo_cnt_ff;
   reg [15:0] nxt_tmo_cnt;
   wire any_hs = |(l_hs[4:1] & dl_on);
   wire tmo_hit = any_hs && (tmo_cnt_ff == HS_TIMEOUT_CYC - 16'h0001);
   always @* begin
      if (!any_hs) nxt_tmo_cnt = 16'h0000;
      else if (tmo_cnt_ff != HS_TIMEOUT_CYC) nxt_tmo_cnt = tmo_cnt_ff + 16'h0001;
      else nxt_tmo_cnt = tmo_cnt_ff;
   end

   // ****************************************
   // leader sequence check
   // ****************************************
   wire [7:0] ldr_x = leader_byte ^ `CSR_LEADER;
   wire ldr_one = (ldr_x != 8'h00) && ((ldr_x & (ldr_x - 8'h01)) == 8'h00);
   wire ldr_take = leader_valid && l_set[1] && l_set[0];
   wire sot_soft = ldr_take && ldr_one;
   wire sot_hard = ldr_take && (ldr_x != 8'h00) && !ldr_one;

   // ****************************************
   // packet header checks
   // ****************************************
   wire [23:0] hfix;
   wire e_zero, e_one, e_two;
   csr_hdr_ecc u_ecc (
      .hdr(pkt_hdr),
      .fixed(hfix),
      .zero(e_zero),
      .single(e_one),
      .multi(e_two)
   );
   wire [5:0] dt = hfix[5:0];
   wire [1:0] vc = hfix[7:6];
   wire [15:0] wc = hfix[23:8];
   wire hdr_use = pkt_hdr_valid && !e_two;
   wire is_long = (dt >= `CSR_DT_LONG_MIN);
   wire dt_ok = (dt <= `CSR_DT_SHORT_MAX) ||
                (dt >= `CSR_DT_YUV_LO && dt <= `CSR_DT_YUV_HI && dt != `CSR_DT_YUV_GAP) ||
                (dt >= `CSR_DT_RGB_LO && dt <= `CSR_DT_RGB_HI) ||
                (dt >= `CSR_DT_RAW_LO && dt <= `CSR_DT_RAW_HI) ||
                (dt >= `CSR_DT_USR_LO && dt <= `CSR_DT_USR_HI);
   wire vc_ok = channel_enable[vc];
   wire bad_dt = hdr_use && !dt_ok;
   wire bad_vc = hdr_use && !vc_ok;
   wire bad_len = hdr_use && dt_ok && is_long &&
                  ((wc == 16'h0000) || (wc > MAX_WORD_COUNT));
   wire pk_ok = hdr_use && dt_ok && vc_ok;
   wire is_fs = pk_ok && (dt == `CSR_DT_FS);
   wire is_fe = pk_ok && (dt == `CSR_DT_FE);

   // ****************************************
   // checksum and frame pairing
   // ****************************************
   reg [1:0] cur_vc_ff;
   reg [3:0] in_frame_ff, crc_bad_ff;
   reg [3:0] nxt_in_frame, nxt_crc_bad;
   wire [3:0] crc_hit = (pkt_crc_valid && !pkt_crc_ok) ? (4'h1 << cur_vc_ff) : 4'h0;
   wire fsync_err = is_fe && !in_frame_ff[vc];
   wire frame_err = is_fe && crc_bad_ff[vc];
   always @* begin
      nxt_in_frame = in_frame_ff;
      nxt_crc_bad = crc_bad_ff | crc_hit;
      if (is_fs) begin
         nxt_in_frame[vc] = 1'b1;
         nxt_crc_bad[vc] = 1'b0;
      end
      if (is_fe) begin
         nxt_in_frame[vc] = 1'b0;
         nxt_crc_bad[vc] = 1'b0;
      end
   end

   // ****************************************
   // sticky error register
   // ****************************************
   reg [17:0] set_vec;
   reg [17:0] nxt_err;
   always @* begin
      set_vec = 18'h00000;
      set_vec[`CSR_E_ESC] = esc_fault;
      set_vec[`CSR_E_CRC0 +: 4] = crc_hit;
      set_vec[`CSR_E_TMO] = tmo_hit;
      set_vec[`CSR_E_ECC1] = pkt_hdr_valid && e_one;
      set_vec[`CSR_E_ECC2] = pkt_hdr_valid && e_two;
      set_vec[`CSR_E_ECCANY] = pkt_hdr_valid && !e_zero;
      set_vec[`CSR_E_ECCOK] = pkt_hdr_valid && e_zero;
      set_vec[`CSR_E_FSYNC] = fsync_err;
      set_vec[`CSR_E_LEN] = bad_len;
      set_vec[`CSR_E_VC] = bad_vc;
      set_vec[`CSR_E_DT] = bad_dt;
      set_vec[`CSR_E_FRAME] = frame_err;
      set_vec[`CSR_E_CTRL] = ctrl_fault;
      set_vec[`CSR_E_SOT] = sot_soft;
      set_vec[`CSR_E_SOTSYNC] = sot_hard;
      // set wins over a clear in the same cycle
      nxt_err = (clear ? 18'h00000 : error_status) | set_vec;
      if (pkt_hdr_valid && !e_zero) nxt_err[`CSR_E_ECCOK] = 1'b0;
      if (!status_enable) nxt_err = 18'h00000;
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tmo_cnt_ff <= 16'h0000;
         cur_vc_ff <= 2'h0;
         in_frame_ff <= 4'h0;
         crc_bad_ff <= 4'h0;
         error_status <= 18'h00000;
         clock_lane_sleep_flag <= 1'b0;
         data_lane_sleep_flags <= 4'h0;
      end else begin
         tmo_cnt_ff <= nxt_tmo_cnt;
         if (pk_ok && is_long) cur_vc_ff <= vc;
         in_frame_ff <= nxt_in_frame;
         crc_bad_ff <= nxt_crc_bad;
         error_status <= nxt_err;
         clock_lane_sleep_flag <= status_enable && l_ulps[0];
         data_lane_sleep_flags <= {4{status_enable}} & l_ulps[4:1] & dl_on;
      end
   end
endmodule // csr_rx_status

// File: pkg/csr_consts.vh
// Purpose: shared constants of the camera receiver status block
// Assumes: 10 MHz core clock, error bus layout fixed at 18 bits
// Notes: definitions only
`ifndef CSR_CONSTS_VH
`define CSR_CONSTS_VH
// ****************************************
// error bus bit positions
// ****************************************
`define CSR_ERR_W 18
`define CSR_E_ESC 0
`define CSR_E_CRC0 1
`define CSR_E_TMO 5
`define CSR_E_ECC1 6
`define CSR_E_ECC2 7
`define CSR_E_ECCANY 8
`define CSR_E_ECCOK 9
`define CSR_E_FSYNC 10
`define CSR_E_LEN 11
`define CSR_E_VC 12
`define CSR_E_DT 13
`define CSR_E_FRAME 14
`define CSR_E_CTRL 15
`define CSR_E_SOT 16
`define CSR_E_SOTSYNC 17
// ****************************************
// timing
// ****************************************
`define CSR_CLK_NS 12'h064
`define CSR_SETTLE_MIN_NS 12'h028
`define CSR_SETTLE_MAX_NS 12'hA1E
`define CSR_HS_TMO_CYC 16'h2710
// ****************************************
// line states {p,n}, escape commands, leader
// ****************************************
`define CSR_LP11 2'h3
`define CSR_LP01 2'h1
`define CSR_LP10 2'h2
`define CSR_LP00 2'h0
`define CSR_ESC_ULPS 8'h1E
`define CSR_ESC_LPDT 8'hE1
`define CSR_ESC_RST 8'h62
`define CSR_LEADER 8'hB8
// ****************************************
// packet header fields and data type codes
// ****************************************
`define CSR_DT_FS 6'h00
`define CSR_DT_FE 6'h01
`define CSR_DT_SHORT_MAX 6'h03
`define CSR_DT_LONG_MIN 6'h10
`define CSR_DT_YUV_LO 6'h18
`define CSR_DT_YUV_HI 6'h1F
`define CSR_DT_YUV_GAP 6'h1B
`define CSR_DT_RGB_LO 6'h20
`define CSR_DT_RGB_HI 6'h24
`define CSR_DT_RAW_LO 6'h28
`define CSR_DT_RAW_HI 6'h2D
`define CSR_DT_USR_LO 6'h30
`define CSR_DT_USR_HI 6'h37
`define CSR_MAX_WC 16'h3840
`define CSR_ROLE_CLK 3'h0
// header code parity masks over header bits 23:0
`define CSR_ECC_M0 24'hF12CB7
`define CSR_ECC_M1 24'hF2555B
`define CSR_ECC_M2 24'h749A6D
`define CSR_ECC_M3 24'hB8E38E
`define CSR_ECC_M4 24'hDF03F0
`define CSR_ECC_M5 24'hEFFC00
`endif

// File: tb/csr_rx_status_asserts.sv
// Purpose: port-level checks of the receiver status block
// Assumes: one clock domain, async active-low reset
// Notes: bound to csr_rx_status
`timescale 1ns/1ps
`include "csr_consts.vh"
module csr_rx_status_asserts #(
   parameter [15:0] HS_TIMEOUT_CYC = 16'h0014,
   parameter [15:0] MAX_WORD_COUNT = 16'h3840
) (
   input wire clk,
   input wire reset_n,
   input wire status_enable,
   input wire clear,
   input wire leader_valid,
   input wire [7:0] leader_byte,
   input wire pkt_hdr_valid,
   input wire pkt_crc_valid,
   input wire pkt_crc_ok,
   input wire [17:0] error_status,
   input wire clock_lane_sleep_flag,
   input wire [3:0] data_lane_sleep_flags
);
// ****************
// error bus relations
// ****************
default clocking cb @(posedge clk); endclocking
default disable iff (!reset_n);
a_sticky_hold:
assert property (status_enable && !clear |=> ((error_status & $past(error_status) & 18'h3FDFF)
   == ($past(error_status) & 18'h3FDFF))) else $error("flag dropped without clear");
a_clear_empty:
assert property (clear && !pkt_hdr_valid && !leader_valid && !pkt_crc_valid
   |=> (error_status & 18'h37FDE) == 18'h00000) else $error("clear left flags set");
a_ecc_split:
assert property ((|error_status[7:6]) |-> error_status[8]) else $error("header fault without summary");
a_hdr_seen:
assert property (pkt_hdr_valid && status_enable |=> error_status[9] || error_status[8])
   else $error("header gave no verdict");
a_bad_drops_ok:
assert property ($rose(error_status[8]) |-> !error_status[9]) else $error("good flag kept on bad header");
a_hdr_cause:
assert property ((|(error_status[14:6] & ~$past(error_status[14:6]))) |-> $past(pkt_hdr_valid))
   else $error("header flag without header");
a_crc_cause:
assert property ((|(error_status[4:1] & ~$past(error_status[4:1])))
   |-> $past(pkt_crc_valid) && !$past(pkt_crc_ok)) else $error("checksum flag without fault");
a_leader_cause:
assert property ((|(error_status[17:16] & ~$past(error_status[17:16]))) |-> $past(leader_valid))
   else $error("leader flag without leader");
a_leader_good:
assert property (leader_valid && leader_byte == `CSR_LEADER && !clear
   ##1 1'b1 |-> error_status[17:16] == $past(error_status[17:16])) else $error("good leader flagged");
a_off_silent:
assert property (!status_enable |=> error_status == 18'h00000 && !clock_lane_sleep_flag
   && data_lane_sleep_flags == 4'h0) else $error("outputs live while disabled");
endmodule // csr_rx_status_asserts
bind csr_rx_status csr_rx_status_asserts #(.HS_TIMEOUT_CYC(HS_TIMEOUT_CYC), .MAX_WORD_COUNT(MAX_WORD_COUNT)) i_chk (
   .clk(clk),
   .reset_n(reset_n),
   .status_enable(status_enable),
   .clear(clear),
   .leader_valid(leader_valid),
   .leader_byte(leader_byte),
   .pkt_hdr_valid(pkt_hdr_valid),
   .pkt_crc_valid(pkt_crc_valid),
   .pkt_crc_ok(pkt_crc_ok),
   .error_status(error_status),
   .clock_lane_sleep_flag(clock_lane_sleep_flag),
   .data_lane_sleep_flags(data_lane_sleep_flags)
);

// File: tb/csr_tx_model.sv
// Purpose: camera transmitter line-state model on five lanes
// Assumes: each escape state held 400 ns, half the 800 ns link period
// Notes: swap input mirrors board wiring of swapped lanes
`timescale 1ns/1ps
`include "csr_consts.vh"
module csr_tx_model (
   input wire clk,
   input wire [4:0] swap,
   output wire [4:0] pad_p,
   output wire [4:0] pad_n
);
// ****************
// line drivers
// ****************
reg [4:0] p_ff = 5'h1F;
reg [4:0] n_ff = 5'h1F;
assign pad_p = (p_ff & ~swap) | (n_ff & swap);
assign pad_n = (n_ff & ~swap) | (p_ff & swap);
task line(input [4:0] mask, input [1:0] st, input integer cyc);
   integer i;
   begin
      @(posedge clk);
      p_ff <= (p_ff & ~mask) | ({5{st[1]}} & mask);
      n_ff <= (n_ff & ~mask) | ({5{st[0]}} & mask);
      for (i = 1; i < cyc; i = i + 1) @(posedge clk);
   end
endtask
// escape entry, then eight marks msb first, each followed by 00
task esc(input [4:0] mask, input [7:0] cmd);
   integer i;
   begin
      line(mask, `CSR_LP10, 4);
      line(mask, `CSR_LP00, 4);
      for (i = 7; i >= 0; i = i - 1) begin
         line(mask, cmd[i] ? `CSR_LP10 : `CSR_LP01, 4);
         line(mask, `CSR_LP00, 4);
      end
   end
endtask
endmodule // csr_tx_model

// File: tb/test_csr_rx_status.sv
// Purpose: self-checking bench of the receiver status block
// Assumes: lanes mapped phys2 clock, 3/4/1/0 data 0..3, phys4 swapped
// Notes: timeout shortened to 20 cycles
`timescale 1ns/1ps
`include "csr_consts.vh"
module test_csr_rx_status;
// ****************
// signals and helpers
// ****************
reg clk = 1'b0;
reg reset_n = 1'b0;
reg [3:0] channel_enable = 4'hF;
reg status_enable = 1'b1;
reg clear = 1'b0;
reg leader_valid = 1'b0;
reg [7:0] leader_byte = 8'h00;
reg pkt_hdr_valid = 1'b0;
reg [31:0] pkt_hdr = 32'h00000000;
reg pkt_crc_valid = 1'b0;
reg pkt_crc_ok = 1'b1;
reg [1:0] lane_count = 2'h3;
reg [11:0] data_lane_settle_time = 12'h0C8;
reg cal_clk = 1'b0;
wire [4:0] pad_p;
wire [4:0] pad_n;
wire [17:0] error_status;
wire clock_lane_sleep_flag;
wire [3:0] data_lane_sleep_flags;
wire [22:0] watch = {clock_lane_sleep_flag, data_lane_sleep_flags, error_status};
reg [77:0] rows [0:9];
integer error_cnt = 0;
integer compares = 0;
integer i;
initial forever #50 clk = ~clk;
// calibration clock at 100 MHz, phy side only, unused by this logic
initial forever #5 cal_clk = ~cal_clk;
csr_tx_model i_tx (.clk(clk), .swap(5'h10), .pad_p(pad_p), .pad_n(pad_n));
csr_rx_status #(.HS_TIMEOUT_CYC(16'h0014)) i_dut (
   .clk(clk), .reset_n(reset_n), .lane_positive_pads(pad_p), .lane_negative_pads(pad_n),
   .lane_role_select(15'h221C), .lane_pn_swap(5'h10), .lane_count(lane_count),
   .channel_enable(channel_enable), .clock_lane_settle_time(12'h028),
   .data_lane_settle_time(data_lane_settle_time),
   .status_enable(status_enable), .clear(clear), .leader_valid(leader_valid), .leader_byte(leader_byte),
   .pkt_hdr_valid(pkt_hdr_valid), .pkt_hdr(pkt_hdr), .pkt_crc_valid(pkt_crc_valid), .pkt_crc_ok(pkt_crc_ok),
   .error_status(error_status), .clock_lane_sleep_flag(clock_lane_sleep_flag),
   .data_lane_sleep_flags(data_lane_sleep_flags)
);
function [31:0] mk(input [23:0] h);
   mk = {2'b00, ^(h & `CSR_ECC_M5), ^(h & `CSR_ECC_M4), ^(h & `CSR_ECC_M3), ^(h & `CSR_ECC_M2),
      ^(h & `CSR_ECC_M1), ^(h & `CSR_ECC_M0), h};
endfunction
task complete_run;
   begin
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   end
endtask
task check(input [17:0] seen, input [17:0] want);
   begin
      compares = compares + 1;
      if (seen !== want) begin
         error_cnt = error_cnt + 1;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   end
endtask
task wait_bit(input integer idx, input val);
   integer n;
   begin
      n = 0;
      while (watch[idx] !== val && n < 40) begin
         @(posedge clk);
         #1 n = n + 1;
      end
      check({17'h0, watch[idx]}, {17'h0, val});
      if (watch[idx] !== val) complete_run;
   end
endtask
task pulse_clear(input [3:0] ce);
   begin
      @(posedge clk);
      clear <= 1'b1;
      channel_enable <= ce;
      @(posedge clk);
      clear <= 1'b0;
   end
endtask
task send_hdr(input [31:0] h);
   begin
      @(posedge clk);
      pkt_hdr_valid <= 1'b1;
      pkt_hdr <= h;
      @(posedge clk);
      pkt_hdr_valid <= 1'b0;
   end
endtask
task send_crc(input ok);
   begin
      @(posedge clk);
      pkt_crc_valid <= 1'b1;
      pkt_crc_ok <= ok;
      @(posedge clk);
      pkt_crc_valid <= 1'b0;
   end
endtask
task send_leader(input [7:0] b);
   begin
      @(posedge clk);
      leader_valid <= 1'b1;
      leader_byte <= b;
      @(posedge clk);
      leader_valid <= 1'b0;
   end
endtask
// ****************
// main sequence
// ****************
initial begin
   rows[0] = {4'hF, 24'h000000, 32'h0, 18'h00200};
   rows[1] = {4'hF, 24'h000041, 32'h0, 18'h00600};
   rows[2] = {4'hF, 24'h00002A, 32'h0, 18'h00A00};
   rows[3] = {4'hF, 24'h38412A, 32'h0, 18'h00A00};
   rows[4] = {4'hF, 24'h38402A, 32'h0, 18'h00200};
   rows[5] = {4'hF, 24'h00101B, 32'h0, 18'h02200};
   rows[6] = {4'hF, 24'h000004, 32'h0, 18'h02200};
   rows[7] = {4'h1, 24'h00106A, 32'h0, 18'h01200};
   rows[8] = {4'hF, 24'h00102A, 32'h00000400, 18'h00140};
   rows[9] = {4'hF, 24'h00102A, 32'h00000C00, 18'h00180};
   repeat (2) @(posedge clk);
   reset_n <= 1'b1;
   @(posedge clk);
   #1 check(error_status, 18'h00000);
   for (i = 0; i < 10; i = i + 1) begin
      pulse_clear(rows[i][77:74]);
      send_hdr(mk(rows[i][73:50]) ^ rows[i][49:18]);
      #1 check(error_status, rows[i][17:0]);
   end
   $display("header table done");
   pulse_clear(4'hF);
   send_hdr(mk(24'h000080));
   send_hdr(mk(24'h0010AA));
   send_crc(1'b0);
   #1 check(error_status, 18'h00208);
   send_hdr(mk(24'h000081));
   #1 check(error_status, 18'h04208);
   repeat (3) @(posedge clk);
   #1 check(error_status, 18'h04208);
   pulse_clear(4'hF);
   #1 check(error_status, 18'h00000);
   $display("frame test done");
   i_tx.line(5'h0C, `CSR_LP01, 4);
   i_tx.line(5'h0C, `CSR_LP00, 12);
   send_leader(`CSR_LEADER);
   #1 check({16'h0, error_status[17:16]}, 18'h0);
   send_leader(8'hB9);
   #1 check({16'h0, error_status[17:16]}, 18'h1);
   send_leader(8'h47);
   #1 check({16'h0, error_status[17:16]}, 18'h3);
   wait_bit(5, 1'b1);
   i_tx.line(5'h0C, `CSR_LP11, 4);
   $display("leader test done");
   pulse_clear(4'hF);
   i_tx.esc(5'h10, `CSR_ESC_ULPS);
   wait_bit(19, 1'b1);
   i_tx.line(5'h10, `CSR_LP10, 4);
   i_tx.line(5'h10, `CSR_LP11, 4);
   wait_bit(19, 1'b0);
   check({17'h0, error_status[0]}, 18'h0);
   i_tx.line(5'h04, `CSR_LP10, 4);
   i_tx.line(5'h04, `CSR_LP00, 4);
   wait_bit(22, 1'b1);
   i_tx.line(5'h04, `CSR_LP10, 4);
   i_tx.line(5'h04, `CSR_LP11, 4);
   $display("sleep test done");
   i_tx.esc(5'h02, 8'h55);
   wait_bit(0, 1'b1);
   i_tx.line(5'h02, `CSR_LP10, 4);
   i_tx.line(5'h02, `CSR_LP11, 4);
   i_tx.line(5'h01, `CSR_LP00, 4);
   wait_bit(15, 1'b1);
   i_tx.line(5'h01, `CSR_LP11, 4);
   $display("line fault test done");
   // lane count only changes under reset; disabled data lane must stay silent
   @(posedge clk);
   reset_n <= 1'b0;
   lane_count <= 2'h0;
   repeat (2) @(posedge clk);
   reset_n <= 1'b1;
   @(posedge clk);
   #1 check(error_status, 18'h00000);
   i_tx.esc(5'h10, `CSR_ESC_ULPS);
   repeat (6) @(posedge clk);
   #1 check({14'h0, data_lane_sleep_flags}, 18'h0);
   i_tx.line(5'h10, `CSR_LP10, 4);
   i_tx.line(5'h10, `CSR_LP11, 4);
   $display("lane count test done");
   @(posedge clk);
   status_enable <= 1'b0;
   repeat (2) @(posedge clk);
   #1 check(error_status, 18'h00000);
   status_enable <= 1'b1;
   $display("disable test done");
   complete_run;
end
endmodule // test_csr_rx_status
